//--- bench/dpll_status_irq_regs_bench.sv
// self-checking bench for the loop status, enable and readout register slice
`default_nettype none
module dpll_status_irq_regs_bench import dpll_regs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic [ADDR_W-1:0]    reg_addr = 9'h000;
  logic                 reg_wr = 1'b0;
  logic [DATA_W-1:0]    reg_wdata = 8'h00;
  logic                 reg_rd = 1'b0;
  logic [5:0]           ind = 6'h00;
  logic [WORD_W-1:0]    offset = 32'h0;
  logic [WORD_W-1:0]    phase = 32'h0;
  logic [NOMINAL_W-1:0] nominal = 40'h0;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 reg_rvalid;
  logic                 flag;
  logic [NOMINAL_W-1:0] tword;
  logic [8:0]           lat;
  logic [8:0]           ie;
  logic [8:0]           base;
  logic [7:0]           m;
  logic [31:0]          v;
  int                   num_errors = 0;
  int                   checks_done = 0;
  int                   cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // indicator bit index equals its field position
  dpll_status_irq_regs u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .loss_of_lock_now(ind[5]), .tracking_state(ind[4]),
    .digital_keep_state(ind[3]), .loop_tuning_offset_limit_active(ind[2]),
    .loop_tuning_offset_slew_limit_active(ind[1]), .phase_slope_limit_active(ind[0]),
    .loop_tuning_offset(offset), .loop_phase_value(phase), .nominal_tuning_word(nominal),
    .channel_loop_irq_flag(flag), .loop_tuning_word(tword));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the whole run takes well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask
  // strobes are one-cycle pulses launched off the falling edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(40'(reg_rdata), 40'(e));
    chk(40'(reg_rvalid), 40'h1);
  endtask
  initial begin
    tick(10);
    rst = 1'b0;
    for (int j = 0; j < 4; j++) begin
      rd(OFS_LOOP_TUNING_OFFSET_B0 + 9'(j), 8'h00);
      rd(OFS_PHASE_B0 + 9'(j), 8'h00);
    end
    rd(OFS_IE_STATE, IE_RESET);
    rd(OFS_IE_LIMIT, IE_RESET);
    wr(OFS_IE_STATE, 8'hff);
    rd(OFS_IE_STATE, 8'h38);
    wr(OFS_IE_LIMIT, 8'hff);
    rd(OFS_IE_LIMIT, 8'h07);
    wr(OFS_IE_STATE, 8'h00);
    wr(OFS_IE_LIMIT, 8'h00);
    wr(9'h1ff, 8'hff);
    rd(9'h1ff, UNMAPPED_READ);
    $display("test defaults done");
    // each event: latch on rise, gate by enable, clear, latch on fall
    for (int i = 0; i < 6; i++) begin
      lat = (i > 2) ? OFS_LAT_STATE : OFS_LAT_LIMIT;
      ie = (i > 2) ? OFS_IE_STATE : OFS_IE_LIMIT;
      m = 8'h01 << i;
      ind[i] = ~ind[i];
      tick(2);
      rd(lat, m);
      chk(40'(flag), 40'h0);
      wr(ie, m);
      tick(2);
      chk(40'(flag), 40'h1);
      wr(lat, m);
      tick(2);
      chk(40'(flag), 40'h0);
      rd(lat, 8'h00);
      ind[i] = ~ind[i];
      tick(3);
      chk(40'(flag), 40'h1);
      wr(ie, 8'h00);
      tick(2);
      chk(40'(flag), 40'h0);
      wr(lat, m);
    end
    $display("test events done");
    // a toggle in the very cycle of its clear must keep the bit set
    ind[1] = 1'b1;
    tick(2);
    reg_addr = OFS_LAT_LIMIT;
    reg_wdata = 8'h02;
    reg_wr = 1'b1;
    ind[1] = 1'b0;
    tick(1);
    reg_wr = 1'b0;
    rd(OFS_LAT_LIMIT, 8'h02);
    wr(OFS_LAT_LIMIT, 8'h02);
    rd(OFS_LAT_LIMIT, 8'h00);
    $display("test set wins done");
    // reset in mid-run: enables drop, a level already high at release is no change
    wr(OFS_IE_STATE, 8'h38);
    rst = 1'b1;
    ind[5] = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(3);
    rd(OFS_LAT_STATE, 8'h00);
    rd(OFS_RT_STATE, 8'h20);
    rd(OFS_RT_LIMIT, 8'h00);
    rd(OFS_IE_STATE, IE_RESET);
    chk(40'(flag), 40'h0);
    $display("test mid-run reset done");
    // second phase value is -2 ns, input lagging feedback
    for (int k = 0; k < 2; k++) begin
      base = k ? OFS_PHASE_B0 : OFS_LOOP_TUNING_OFFSET_B0;
      v = k ? 32'hffff_f800 : 32'h8765_4321;
      offset = v;
      phase = v;
      wr(base, 8'h5a);
      rd(base, v[7:0]);
      offset = ~v;
      phase = ~v;
      rd(base + 9'h1, v[15:8]);
      rd(base + 9'h2, v[23:16]);
      rd(base + 9'h3, v[31:24]);
      rd(base, ~v[7:0]);
      offset = v;
      phase = v;
      rd(base, v[7:0]);
    end
    $display("test readouts done");
    offset = 32'h8765_4321;
    nominal = 40'h12_3456_7890;
    tick(2);
    chk(tword, 40'h11_bbbb_bbb1);
    $display("test tuning word done");
    end_sim;
  end
endmodule
`default_nettype wire

//--- bench/dpll_status_irq_sva.sv
// concurrent checks on the loop status, enable and readout register slice
`default_nettype none
module dpll_status_irq_sva
  import dpll_regs_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic [ADDR_W-1:0]    reg_addr,
  input wire logic                 reg_wr,
  input wire logic [DATA_W-1:0]    reg_wdata,
  input wire logic                 reg_rd,
  input wire logic [DATA_W-1:0]    reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 loss_of_lock_now,
  input wire logic                 tracking_state,
  input wire logic                 digital_keep_state,
  input wire logic                 loop_tuning_offset_limit_active,
  input wire logic                 loop_tuning_offset_slew_limit_active,
  input wire logic                 phase_slope_limit_active,
  input wire logic [WORD_W-1:0]    loop_tuning_offset,
  input wire logic [NOMINAL_W-1:0] nominal_tuning_word,
  input wire logic                 channel_loop_irq_flag,
  input wire logic [NOMINAL_W-1:0] loop_tuning_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]           ie_st;
  logic [7:0]           ie_lim;
  logic [5:0]           en;
  logic [NOMINAL_W-1:0] sum;
  // shadow enables, so the flag checks know which events are armed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ie_st <= 8'h00;
      ie_lim <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_IE_STATE) begin
      ie_st <= reg_wdata & STATE_MASK;
    end else if (reg_wr && reg_addr == OFS_IE_LIMIT) begin
      ie_lim <= reg_wdata & LIMIT_MASK;
    end
  end
  // sign-extended offset added to the nominal word
  assign en = {ie_st[5:3], ie_lim[2:0]};
  assign sum = nominal_tuning_word + {{8{loop_tuning_offset[31]}}, loop_tuning_offset};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // first edge after release only primes history, so it is skipped
  property toggle_flags(logic x, logic e);
    !$past(rst) && $changed(x) ##1 e |=> channel_loop_irq_flag;
  endproperty
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  a_answer_only_read: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr[8:7] == 2'b11 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_state_en_read: assert property (reg_rd && reg_addr == OFS_IE_STATE |=> reg_rdata == $past(ie_st))
    else $error("state enable readback wrong");
  a_limit_en_read: assert property (reg_rd && reg_addr == OFS_IE_LIMIT |=> reg_rdata == $past(ie_lim))
    else $error("limit enable readback wrong");
  a_flag_needs_en: assert property (!$past(rst) && $past(en) == 6'h00 |-> !channel_loop_irq_flag)
    else $error("flag high with all enables off");
  a_slew_sets_flag: assert property (toggle_flags(loop_tuning_offset_slew_limit_active, en[1]))
    else $error("slew change did not raise flag");
  a_slope_sets_flag: assert property (toggle_flags(phase_slope_limit_active, en[0]))
    else $error("slope change did not raise flag");
  a_lock_sets_flag: assert property (toggle_flags(loss_of_lock_now, en[5]))
    else $error("lock change did not raise flag");
  a_track_sets_flag: assert property (toggle_flags(tracking_state, en[4]))
    else $error("tracking change did not raise flag");
  a_keep_sets_flag: assert property (toggle_flags(digital_keep_state, en[3]))
    else $error("keep state change did not raise flag");
  a_flimit_sets_flag: assert property (toggle_flags(loop_tuning_offset_limit_active, en[2]))
    else $error("frequency limit change did not raise flag");
  a_tuning_word_sum: assert property (!$past(rst) |-> loop_tuning_word == $past(sum))
    else $error("tuning word not nominal plus offset");
  c_read: cover property (reg_rvalid);
  c_flag: cover property ($rose(channel_loop_irq_flag));
  c_clear: cover property (reg_wr && reg_addr == OFS_LAT_LIMIT);
endmodule
bind dpll_status_irq_regs dpll_status_irq_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .loss_of_lock_now(loss_of_lock_now),
  .tracking_state(tracking_state), .digital_keep_state(digital_keep_state),
  .loop_tuning_offset_limit_active(loop_tuning_offset_limit_active),
  .loop_tuning_offset_slew_limit_active(loop_tuning_offset_slew_limit_active),
  .phase_slope_limit_active(phase_slope_limit_active),
  .loop_tuning_offset(loop_tuning_offset), .nominal_tuning_word(nominal_tuning_word),
  .channel_loop_irq_flag(channel_loop_irq_flag), .loop_tuning_word(loop_tuning_word));
`default_nettype wire

//--- pkg/dpll_regs_pkg.sv
// constants for the loop status, interrupt enable and readout register slice
`default_nettype none
package dpll_regs_pkg;
  // register port widths, event count, lanes per readout and readout count
  localparam int ADDR_W    = 9;
  localparam int DATA_W    = 8;
  localparam int WORD_W    = 32;
  localparam int NOMINAL_W = 40;
  localparam int EVT_N     = 6;
  localparam int LANE_N    = 4;
  localparam int READOUT_N = 2;

  // register offsets
  localparam logic [8:0] OFS_RT_STATE   = 9'h056;
  localparam logic [8:0] OFS_RT_LIMIT   = 9'h057;
  localparam logic [8:0] OFS_LAT_STATE  = 9'h059;
  localparam logic [8:0] OFS_LAT_LIMIT  = 9'h05a;
  localparam logic [8:0] OFS_IE_STATE   = 9'h05b;
  localparam logic [8:0] OFS_IE_LIMIT   = 9'h05c;
  localparam logic [8:0] OFS_LOOP_TUNING_OFFSET_B0    = 9'h065;
  localparam logic [8:0] OFS_LOOP_TUNING_OFFSET_B1    = 9'h066;
  localparam logic [8:0] OFS_LOOP_TUNING_OFFSET_B2    = 9'h067;
  localparam logic [8:0] OFS_LOOP_TUNING_OFFSET_B3    = 9'h068;
  localparam logic [8:0] OFS_PHASE_B0   = 9'h07d;
  localparam logic [8:0] OFS_PHASE_B1   = 9'h07e;
  localparam logic [8:0] OFS_PHASE_B2   = 9'h07f;
  localparam logic [8:0] OFS_PHASE_B3   = 9'h080;

  // field positions: an event's index equals its bit position in its register
  localparam int BIT_LOCK_LOSS   = 5;
  localparam int BIT_TRACKING    = 4;
  localparam int BIT_KEEP_STATE  = 3;
  localparam int BIT_LOOP_TUNING_OFFSET_LIMIT  = 2;
  localparam int BIT_LOOP_TUNING_OFFSET_SLEW   = 1;
  localparam int BIT_PHASE_SLOPE = 0;

  // implemented bits of the state and limit registers
  localparam logic [7:0] STATE_MASK = 8'h38;
  localparam logic [7:0] LIMIT_MASK = 8'h07;

  // reset values and the unmapped read value
  localparam logic [7:0]  IE_RESET      = 8'h00;
  localparam logic [31:0] READOUT_RESET = 32'h0000_0000;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  // phase readout scale: one count is 2 to this power nanoseconds
  localparam int PHASE_LSB_EXP_NS = -10;

  // readout snapshot state
  typedef enum logic [0:0] {
    CAP_IDLE = 1'b0,
    CAP_OPEN = 1'b1
  } cap_state_t;
endpackage
`default_nettype wire

//--- pkg/latch_if.sv
// carrier between the register slice and its change latch
`default_nettype none
interface latch_if;
  logic [5:0] indicator;  // real-time indicators, same clock
  logic [5:0] clear;      // write-one-to-clear pulses
  logic [5:0] latched;    // sticky change bits
  modport regs_side  (output indicator, output clear, input latched);
  modport latch_side (input indicator, input clear, output latched);
endinterface
`default_nettype wire

//--- src/change_latch.sv
// sticky change-of-state latch for the loop status indicators
`default_nettype none
module change_latch
  import dpll_regs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  latch_if.latch_side     lif
);
  logic             primed;
  logic [EVT_N-1:0] prev;
  logic [EVT_N-1:0] latched;
  logic [EVT_N-1:0] toggled;
  logic [EVT_N-1:0] next_latched;

  // no toggle is reported on the first cycle: prev holds a reset value, not history
  assign toggled      = primed ? (lif.indicator ^ prev) : '0;
  // a toggle in the clearing cycle still sets the bit
  assign next_latched = (latched & ~lif.clear) | toggled;
  assign lif.latched  = latched;

  // history and sticky bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      primed  <= 1'b0;
      prev    <= '0;
      latched <= '0;
    end else begin
      primed  <= 1'b1;
      prev    <= lif.indicator;
      latched <= next_latched;
    end
  end
endmodule
`default_nettype wire

//--- src/dpll_status_irq_regs.sv
// loop status, interrupt enable and coherent readout register slice
`default_nettype none
module dpll_status_irq_regs
  import dpll_regs_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_rd,
  output logic      [DATA_W-1:0]    reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 loss_of_lock_now,
  input  wire logic                 tracking_state,
  input  wire logic                 digital_keep_state,
  input  wire logic                 loop_tuning_offset_limit_active,
  input  wire logic                 loop_tuning_offset_slew_limit_active,
  input  wire logic                 phase_slope_limit_active,
  input  wire logic [WORD_W-1:0]    loop_tuning_offset,
  input  wire logic [WORD_W-1:0]    loop_phase_value,
  input  wire logic [NOMINAL_W-1:0] nominal_tuning_word,
  output logic                      channel_loop_irq_flag,
  output logic      [NOMINAL_W-1:0] loop_tuning_word
);

  // window test, shared by both readouts
  function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff      = addr - base;
    in_window = (addr >= base) && (diff < ADDR_W'(LANE_N));
  endfunction

  // byte lane inside a readout window
  function automatic logic [1:0] lane_of(input logic [ADDR_W-1:0] addr,
                                         input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff    = addr - base;
    lane_of = diff[1:0];
  endfunction

  latch_if lif ();

  // enable registers, stored already masked so unused bits read zero
  logic [DATA_W-1:0] ie_state;
  logic [DATA_W-1:0] ie_limit;
  logic [DATA_W-1:0] next_ie_state;
  logic [DATA_W-1:0] next_ie_limit;

  // write strobes
  logic wr_ie_state;
  logic wr_ie_limit;
  logic wr_lat_state;
  logic wr_lat_limit;

  // interrupt path
  logic [EVT_N-1:0] enables;
  logic [EVT_N-1:0] gated;
  logic             next_irq;

  // read path
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] rt_state_val;
  logic [DATA_W-1:0] rt_limit_val;
  logic [DATA_W-1:0] lat_state_val;
  logic [DATA_W-1:0] lat_limit_val;

  // readout snapshots, index 0 frequency offset, index 1 phase
  logic [WORD_W-1:0]    live      [READOUT_N];
  logic [ADDR_W-1:0]    base      [READOUT_N];
  logic [WORD_W-1:0]    snap      [READOUT_N];
  logic [LANE_N-1:0]    seen      [READOUT_N];
  cap_state_t           cap_state [READOUT_N];
  logic                 hit       [READOUT_N];
  logic [DATA_W-1:0]    rd_byte   [READOUT_N];

  // actual tuning word
  logic [NOMINAL_W-1:0] next_tuning_word;

  // indicators and write-one-to-clear pulses go to the change latch
  assign lif.indicator = {loss_of_lock_now, tracking_state, digital_keep_state,
                          loop_tuning_offset_limit_active, loop_tuning_offset_slew_limit_active,
                          phase_slope_limit_active};

  // address decode for writes; readout offsets take no write at all
  assign wr_ie_state  = reg_wr && (reg_addr == OFS_IE_STATE);
  assign wr_ie_limit  = reg_wr && (reg_addr == OFS_IE_LIMIT);
  assign wr_lat_state = reg_wr && (reg_addr == OFS_LAT_STATE);
  assign wr_lat_limit = reg_wr && (reg_addr == OFS_LAT_LIMIT);

  // each clear pulse is limited to the bits its register holds
  assign lif.clear = {wr_lat_state ? reg_wdata[BIT_LOCK_LOSS:BIT_KEEP_STATE] : 3'b000,
                      wr_lat_limit ? reg_wdata[BIT_LOOP_TUNING_OFFSET_LIMIT:BIT_PHASE_SLOPE] : 3'b000};

  change_latch u_change_latch (
    .clk_sys (clk_sys),
    .rst     (rst),
    .lif     (lif)
  );

  // new enable values; unused bits are dropped on the way in
  assign next_ie_state = wr_ie_state ? (reg_wdata & STATE_MASK) : ie_state;
  assign next_ie_limit = wr_ie_limit ? (reg_wdata & LIMIT_MASK) : ie_limit;

  // enable registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ie_state <= IE_RESET;
      ie_limit <= IE_RESET;
    end else begin
      ie_state <= next_ie_state;
      ie_limit <= next_ie_limit;
    end
  end

  // event index equals bit position, so the two enables just merge
  assign enables = ie_state[EVT_N-1:0] | ie_limit[EVT_N-1:0];
  assign gated   = lif.latched & enables;

  // loop flag follows any enabled latched bit
  assign next_irq = gated[BIT_LOCK_LOSS]
                  | gated[BIT_TRACKING]
                  | gated[BIT_KEEP_STATE]
                  | gated[BIT_LOOP_TUNING_OFFSET_LIMIT]
                  | gated[BIT_LOOP_TUNING_OFFSET_SLEW]
                  | gated[BIT_PHASE_SLOPE];

  // live readout sources and their windows
  assign live[0] = loop_tuning_offset;
  assign live[1] = loop_phase_value;
  assign base[0] = OFS_LOOP_TUNING_OFFSET_B0;
  assign base[1] = OFS_PHASE_B0;

  // one snapshot engine per readout
  genvar k;
  generate
    for (k = 0; k < READOUT_N; k++) begin : g_readout
      logic [1:0]        lane;
      logic              capture;
      logic [WORD_W-1:0] next_snap;
      logic [LANE_N-1:0] lane_bit;
      logic [LANE_N-1:0] marked;
      logic              done;

      assign hit[k]    = reg_rd && in_window(reg_addr, base[k]);
      assign lane      = lane_of(reg_addr, base[k]);
      assign lane_bit  = LANE_N'(1) << lane;
      // a fresh sequence, or a repeat of a byte already read, takes a new copy
      assign capture   = hit[k] && ((cap_state[k] == CAP_IDLE) || (|(seen[k] & lane_bit)));
      assign next_snap = capture ? live[k] : snap[k];
      assign marked    = (capture ? '0 : seen[k]) | lane_bit;
      assign done      = &marked;
      // the byte read comes from the copy taken for this very read, or from the held copy if this read takes none
      assign rd_byte[k] = next_snap[lane*DATA_W +: DATA_W];

      // snapshot word and the bytes of it already handed out
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          snap[k]      <= READOUT_RESET;
          seen[k]      <= '0;
          cap_state[k] <= CAP_IDLE;
        end else if (hit[k]) begin
          snap[k]      <= next_snap;
          seen[k]      <= done ? '0 : marked;
          cap_state[k] <= done ? CAP_IDLE : CAP_OPEN;
        end
      end
    end
  endgenerate

  // status register images
  assign rt_state_val  = {2'b00, loss_of_lock_now, tracking_state, digital_keep_state, 3'b000};
  assign rt_limit_val  = {5'b00000, loop_tuning_offset_limit_active, loop_tuning_offset_slew_limit_active,
                          phase_slope_limit_active};
  assign lat_state_val = {2'b00, lif.latched[BIT_LOCK_LOSS:BIT_KEEP_STATE], 3'b000};
  assign lat_limit_val = {5'b00000, lif.latched[BIT_LOOP_TUNING_OFFSET_LIMIT:BIT_PHASE_SLOPE]};

  // read decode; unmapped offsets answer zero
  always_comb begin
    if (!reg_rd) begin
      next_rdata = reg_rdata;
    end else if (reg_addr == OFS_RT_STATE) begin
      next_rdata = rt_state_val;
    end else if (reg_addr == OFS_RT_LIMIT) begin
      next_rdata = rt_limit_val;
    end else if (reg_addr == OFS_LAT_STATE) begin
      next_rdata = lat_state_val;
    end else if (reg_addr == OFS_LAT_LIMIT) begin
      next_rdata = lat_limit_val;
    end else if (reg_addr == OFS_IE_STATE) begin
      next_rdata = ie_state;
    end else if (reg_addr == OFS_IE_LIMIT) begin
      next_rdata = ie_limit;
    end else if (hit[0]) begin
      next_rdata = rd_byte[0];
    end else if (hit[1]) begin
      next_rdata = rd_byte[1];
    end else begin
      next_rdata = UNMAPPED_READ;
    end
  end

  // signed offset widened onto the 40-bit nominal word
  assign next_tuning_word = nominal_tuning_word
                          + {{(NOMINAL_W-WORD_W){loop_tuning_offset[WORD_W-1]}},
                             loop_tuning_offset};

  // registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata             <= '0;
      reg_rvalid            <= 1'b0;
      channel_loop_irq_flag <= 1'b0;
      loop_tuning_word      <= '0;
    end else begin
      reg_rdata             <= next_rdata;
      reg_rvalid            <= reg_rd;
      channel_loop_irq_flag <= next_irq;
      loop_tuning_word      <= next_tuning_word;
    end
  end
endmodule
`default_nettype wire
